// ---- common/ufm_map.svh ----
// register offsets, field positions, reset values and counts of the serial port
// assumes inclusion by the serial port core only
`ifndef UFM_MAP_SVH
`define UFM_MAP_SVH

`define UFM_CTRL_ADDR 8'h98
`define UFM_DATA_ADDR 8'h99
`define UFM_CTRL_BITBASE 5'h13
`define UFM_CTRL_RESET 8'h40

`define UFM_BIT_MODE 7
`define UFM_BIT_FIXED 6
`define UFM_BIT_MCE 5
`define UFM_BIT_REN 4
`define UFM_BIT_TB8 3
`define UFM_BIT_RB8 2
`define UFM_BIT_TI 1
`define UFM_BIT_RI 0

`define UFM_LAST_DATA_BIT 4'h7
`define UFM_TMR_TOP 8'hFF
`define UFM_UNMAPPED_READ 8'h00

`endif

// ---- common/ufm_pkg.sv ----
// types shared by the serial port core and its bench
// assumes the offsets and counts of ufm_map.svh
package ufm_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic mode;
    logic fixed_one;
    logic mce;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
  } ufm_ctrl_t;

  // byte access to the special register space
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ufm_sfr_req_t;

  // single-bit set or clear access
  typedef struct packed {
    logic [7:0] addr;
    logic val;
    logic wr;
  } ufm_bit_req_t;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_NINTH,
    TX_STOP
  } ufm_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_NINTH,
    RX_STOP
  } ufm_rx_state_t;

endpackage : ufm_pkg

// ---- rtl/ufm_fifo.sv ----
// first-in first-out buffer with registered output stage
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module ufm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } ufm_fifo_state_t;

  ufm_fifo_state_t q;
  ufm_fifo_state_t d;
  logic push;
  logic take;

  always_comb begin
    d = q;
    push = in_valid && q.in_ready;
    take = (q.count != '0) && (!q.out_valid || out_ready);
    if (push) begin
      d.mem[q.wptr] = in_data;
      d.wptr = (q.wptr == PW'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
    end
    if (out_ready && q.out_valid) begin
      d.out_valid = 1'b0;
    end
    if (take) begin
      d.out_data = q.mem[q.rptr];
      d.out_valid = 1'b1;
      d.rptr = (q.rptr == PW'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
    end
    d.count = q.count + CW'(push) - CW'(take);
    d.in_ready = (d.count != CW'(DEPTH));
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.in_ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.in_ready;
  assign out_valid = q.out_valid;
  assign out_data = q.out_data;

  a_fifo_no_overfill: assert property (@(posedge core_clk)
    disable iff (sys_rst) (q.count == CW'(DEPTH)) |-> !q.in_ready)
    else $error("fifo accepts data while full");

endmodule : ufm_fifo

// ---- rtl/ufm_uart.sv ----
// serial port core: control register, data buffer, transmitter, receiver
// assumes timer tick and register strobes are synchronous to core_clk
//
// What this block does
// - mode bit picks 8-bit or 9-bit frame
// - 8-bit frame: start, eight lsb-first, stop
// - 8-bit receive: data to buffer, stop to rb8
// - data buffer write starts a transmission
// - transmit-done set at stop bit start
// - receive starts only while receive enable is set
// - 8-bit load needs done clear, stop if mce
// - overrun keeps the earlier received byte
// - failed load changes buffer, rb8, done nothing
// - interrupt when enabled and either flag set
// - 9-bit frame adds programmable ninth bit
// - transmitted ninth bit follows tb8
// - 9-bit receive: ninth to rb8, stop ignored
// - 9-bit load needs done clear, ninth if mce
// - mce in 9-bit: only ninth-one characters count
// - control bit 6 reads one, ignores writes
// - control at 0x98 with bit set/clear
// - flags cleared only by software writes
// - buffer writes transmit, reads return receive
// - bit rate is half the timer overflow rate
`timescale 1ns/10ps
`include "ufm_map.svh"
module ufm_uart #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire ufm_pkg::ufm_sfr_req_t sfr_req,
  input wire ufm_pkg::ufm_bit_req_t sfr_bit,
  output logic [7:0] sfr_rdata,
  input wire logic t1_tick,
  input wire logic [7:0] t1_reload,
  input wire logic irq_enable,
  input wire logic serial_receive_line,
  output logic serial_transmit_line,
  output logic port_irq,
  output logic tx_room
);

  typedef struct packed {
    ufm_pkg::ufm_ctrl_t ctl;
    logic [7:0] rbuf;
    logic [7:0] rdata;
    logic [2:0] rx_sync;
    logic rx_filt;
    logic [7:0] tx_tmr;
    logic tx_ph;
    logic [7:0] rx_tmr;
    logic rx_ph;
    ufm_pkg::ufm_tx_state_t tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_nine;
    logic txd;
    ufm_pkg::ufm_rx_state_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic rx_nine;
    logic rx_b9;
    logic irq;
  } ufm_state_t;

  ufm_state_t q;
  ufm_state_t d;

  logic fifo_push;
  logic fifo_pop;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_ready;
  logic tx_ovf;
  logic rx_ovf;
  logic tx_bit;
  logic rx_smp;
  logic rx_fall;
  logic rx_b9_now;
  logic rx_load_ok;
  logic [7:0] bit_img;

  // store a control image; bit 6 stays one
  function automatic ufm_pkg::ufm_ctrl_t ctl_store(input logic [7:0] v);
    ufm_pkg::ufm_ctrl_t c;
    c = ufm_pkg::ufm_ctrl_t'(v);
    c.fixed_one = 1'b1;
    return c;
  endfunction : ctl_store

  // byte address decode
  function automatic logic hits(input ufm_pkg::ufm_sfr_req_t r,
                                input logic [7:0] a);
    return r.addr == a;
  endfunction : hits

  ufm_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .in_data(sfr_req.wdata),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_comb begin
    d = q;
    fifo_pop = 1'b0;
    bit_img = q.ctl;
    rx_b9_now = 1'b0;
    rx_load_ok = 1'b0;

    // receive line: three stages, change taken when last two agree
    d.rx_sync = {q.rx_sync[1:0], serial_receive_line};
    if (q.rx_sync[1] == q.rx_sync[2]) begin
      d.rx_filt = q.rx_sync[2];
    end
    rx_fall = q.rx_filt && (q.rx_sync[1] == q.rx_sync[2])
              && !q.rx_sync[2];

    // timers: reload on overflow, bit every second overflow
    tx_ovf = t1_tick && (q.tx_tmr == `UFM_TMR_TOP);
    rx_ovf = t1_tick && (q.rx_tmr == `UFM_TMR_TOP);
    if (t1_tick) begin
      d.tx_tmr = tx_ovf ? t1_reload : q.tx_tmr + 8'h01;
      d.rx_tmr = rx_ovf ? t1_reload : q.rx_tmr + 8'h01;
    end
    if (tx_ovf) begin
      d.tx_ph = !q.tx_ph;
    end
    if (rx_ovf) begin
      d.rx_ph = !q.rx_ph;
    end
    tx_bit = tx_ovf && q.tx_ph;
    rx_smp = rx_ovf && q.rx_ph;

    // software access to the control register
    if (sfr_req.wr && hits(sfr_req, `UFM_CTRL_ADDR)) begin
      d.ctl = ctl_store(sfr_req.wdata);
    end
    if (sfr_bit.wr && (sfr_bit.addr[7:3] == `UFM_CTRL_BITBASE)) begin
      bit_img[sfr_bit.addr[2:0]] = sfr_bit.val;
      d.ctl = ctl_store(bit_img);
    end

    // data buffer writes go to the transmit queue
    fifo_push = sfr_req.wr && hits(sfr_req, `UFM_DATA_ADDR);

    if (sfr_req.rd) begin
      if (hits(sfr_req, `UFM_CTRL_ADDR)) begin
        d.rdata = q.ctl;
      end else if (hits(sfr_req, `UFM_DATA_ADDR)) begin
        d.rdata = q.rbuf;
      end else begin
        d.rdata = `UFM_UNMAPPED_READ;
      end
    end

    // transmitter
    case (q.tx_st)
      ufm_pkg::TX_IDLE: begin
        d.txd = 1'b1;
        if (tx_bit && fifo_valid) begin
          fifo_pop = 1'b1;
          d.tx_sh = fifo_data;
          d.tx_nine = q.ctl.mode;
          d.txd = 1'b0;
          d.tx_st = ufm_pkg::TX_START;
        end
      end
      ufm_pkg::TX_START: begin
        if (tx_bit) begin
          d.txd = q.tx_sh[0];
          d.tx_sh = {1'b0, q.tx_sh[7:1]};
          d.tx_cnt = 4'h0;
          d.tx_st = ufm_pkg::TX_DATA;
        end
      end
      ufm_pkg::TX_DATA: begin
        if (tx_bit) begin
          if (q.tx_cnt == `UFM_LAST_DATA_BIT) begin
            if (q.tx_nine) begin
              d.txd = q.ctl.tb8;
              d.tx_st = ufm_pkg::TX_NINTH;
            end else begin
              d.txd = 1'b1;
              d.ctl.ti = 1'b1;
              d.tx_st = ufm_pkg::TX_STOP;
            end
          end else begin
            d.txd = q.tx_sh[0];
            d.tx_sh = {1'b0, q.tx_sh[7:1]};
            d.tx_cnt = q.tx_cnt + 4'h1;
          end
        end
      end
      ufm_pkg::TX_NINTH: begin
        if (tx_bit) begin
          d.txd = 1'b1;
          d.ctl.ti = 1'b1;
          d.tx_st = ufm_pkg::TX_STOP;
        end
      end
      ufm_pkg::TX_STOP: begin
        if (tx_bit) begin
          d.tx_st = ufm_pkg::TX_IDLE;
        end
      end
      default: begin
        d.txd = 1'b1;
        d.tx_st = ufm_pkg::TX_IDLE;
      end
    endcase

    // receiver
    case (q.rx_st)
      ufm_pkg::RX_IDLE: begin
        if (q.ctl.ren && rx_fall) begin
          d.rx_tmr = t1_reload;
          d.rx_ph = 1'b1;
          d.rx_nine = q.ctl.mode;
          d.rx_st = ufm_pkg::RX_START;
        end
      end
      ufm_pkg::RX_START: begin
        if (rx_smp) begin
          d.rx_cnt = 4'h0;
          d.rx_st = q.rx_filt ? ufm_pkg::RX_IDLE : ufm_pkg::RX_DATA;
        end
      end
      ufm_pkg::RX_DATA: begin
        if (rx_smp) begin
          d.rx_sh = {q.rx_filt, q.rx_sh[7:1]};
          d.rx_cnt = q.rx_cnt + 4'h1;
          if (q.rx_cnt == `UFM_LAST_DATA_BIT) begin
            d.rx_st = q.rx_nine ? ufm_pkg::RX_NINTH : ufm_pkg::RX_STOP;
          end
        end
      end
      ufm_pkg::RX_NINTH: begin
        if (rx_smp) begin
          d.rx_b9 = q.rx_filt;
          d.rx_st = ufm_pkg::RX_STOP;
        end
      end
      ufm_pkg::RX_STOP: begin
        if (rx_smp) begin
          rx_b9_now = q.rx_nine ? q.rx_b9 : q.rx_filt;
          rx_load_ok = !q.ctl.ri
                       && (!q.ctl.mce || rx_b9_now);
          if (rx_load_ok) begin
            d.rbuf = q.rx_sh;
            d.ctl.rb8 = rx_b9_now;
            d.ctl.ri = 1'b1;
          end
          d.rx_st = ufm_pkg::RX_IDLE;
        end
      end
      default: begin
        d.rx_st = ufm_pkg::RX_IDLE;
      end
    endcase

    d.irq = irq_enable && (d.ctl.ti || d.ctl.ri);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.ctl <= `UFM_CTRL_RESET;
      q.txd <= 1'b1;
      q.rx_sync <= 3'h7;
      q.rx_filt <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata = q.rdata;
  assign serial_transmit_line = q.txd;
  assign port_irq = q.irq;
  assign tx_room = fifo_ready;

  default clocking ufm_cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_fixed_bit_one: assert property (
    (sfr_req.rd && sfr_req.addr == `UFM_CTRL_ADDR) |=> sfr_rdata[6])
    else $error("control bit 6 read as zero");

  a_ti_at_stop: assert property (
    (q.tx_st != ufm_pkg::TX_STOP && d.tx_st == ufm_pkg::TX_STOP)
    |=> (q.ctl.ti && serial_transmit_line))
    else $error("transmit done not set at stop bit");

  a_start_bit_low: assert property (
    (q.tx_st == ufm_pkg::TX_START) |-> !serial_transmit_line)
    else $error("start bit not low");

  a_ninth_tx_bit: assert property (
    (q.tx_st == ufm_pkg::TX_DATA && d.tx_st == ufm_pkg::TX_NINTH)
    |=> serial_transmit_line == $past(q.ctl.tb8))
    else $error("ninth bit differs from tb8");

  a_rx_gated_off: assert property (
    (q.rx_st == ufm_pkg::RX_IDLE && !q.ctl.ren) |=> q.rx_st == ufm_pkg::RX_IDLE)
    else $error("receiver started while disabled");

  a_overrun_keeps: assert property (
    (q.rx_st == ufm_pkg::RX_STOP && rx_smp && q.ctl.ri)
    |=> q.rbuf == $past(q.rbuf))
    else $error("overrun overwrote the receive buffer");

  a_mce_filter: assert property (
    (q.rx_st == ufm_pkg::RX_STOP && rx_smp && q.rx_nine && q.ctl.mce
     && !q.rx_b9 && !sfr_req.wr && !sfr_bit.wr)
    |=> (q.rbuf == $past(q.rbuf)) && (q.ctl.ri == $past(q.ctl.ri)))
    else $error("data character passed the address filter");

  a_eight_bit_load: assert property (
    (q.rx_st == ufm_pkg::RX_STOP && rx_smp && !q.rx_nine && !q.ctl.ri
     && !q.ctl.mce)
    |=> q.ctl.ri && q.rbuf == $past(q.rx_sh) && q.ctl.rb8 == $past(q.rx_filt))
    else $error("8-bit character not loaded");

  a_irq_follows: assert property (
    (irq_enable && (q.ctl.ti || q.ctl.ri) && !sfr_req.wr && !sfr_bit.wr)
    |=> port_irq)
    else $error("interrupt missing with flag set");

endmodule : ufm_uart

// ---- verification/ufm_remote.sv ----
// remote serial partner: sends frames on the receive line, captures transmit
// assumes 8 core_clk cycles per bit and an idle-high line
`timescale 1ns/10ps
module ufm_remote (
  input wire logic core_clk,
  input wire logic nine_mode,
  input wire logic tx_line,
  output logic rx_line
);
  logic [10:0] got[$];
  logic [10:0] sh;
  initial rx_line = 1'b1;
  // start, data lsb first, optional ninth, stop
  task automatic send(input logic [7:0] d, input logic b9, input logic stp);
    logic [10:0] f;
    f = nine_mode ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < 10 + nine_mode; i++) begin
      // caller picks the ninth bit: address one, data zero
      @(negedge core_clk) rx_line = f[i];
      repeat (7) @(negedge core_clk);
    end
    @(negedge core_clk) rx_line = 1'b1;
  endtask : send
  // capture of transmitted frames, sampled mid-bit
  always begin
    @(negedge tx_line);
    sh = '0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 10 + nine_mode; i++) begin
      sh[i] = tx_line;
      if (i < 9 + nine_mode) begin
        repeat (8) @(posedge core_clk);
      end
    end
    got.push_back(sh);
  end
endmodule : ufm_remote

// ---- verification/ufm_uart_tb_top.sv ----
// bench of the serial port core against the remote partner
// assumes timer reload 0xFC with a tick every cycle: 8 cycles per bit
`timescale 1ns/10ps
module ufm_uart_tb_top;
  logic core_clk, sys_rst, t1_tick, irq_enable, rx_line, tx_line;
  logic port_irq, tx_room, nine;
  logic [7:0] t1_reload, sfr_rdata, rv;
  ufm_pkg::ufm_sfr_req_t sfr_req;
  ufm_pkg::ufm_bit_req_t sfr_bit;
  int fails, check_count;
  ufm_uart dut_u (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sfr_req(sfr_req),
    .sfr_bit(sfr_bit),
    .sfr_rdata(sfr_rdata),
    .t1_tick(t1_tick),
    .t1_reload(t1_reload),
    .irq_enable(irq_enable),
    .serial_receive_line(rx_line),
    .serial_transmit_line(tx_line),
    .port_irq(port_irq),
    .tx_room(tx_room)
  );
  ufm_remote remote_u (
    .core_clk(core_clk),
    .nine_mode(nine),
    .tx_line(tx_line),
    .rx_line(rx_line)
  );
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge core_clk) sfr_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk) sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge core_clk) sfr_req.rd = 1'b0;
    @(negedge core_clk) rv = sfr_rdata;
  endtask : rd
  task automatic bw(input logic [7:0] n, input logic v);
    @(negedge core_clk) sfr_bit = '{addr: 8'h98 + n, val: v, wr: 1'b1};
    @(negedge core_clk) sfr_bit.wr = 1'b0;
  endtask : bw
  // waits for one captured frame, bounded
  task automatic tx_expect(input logic [10:0] exp);
    int n;
    n = 0;
    while (remote_u.got.size() == 0 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk((remote_u.got.size() > 0) ? remote_u.got.pop_front() : 11'h7FF, exp);
  endtask : tx_expect
  // buffer byte and rb8/ri after a received frame
  task automatic rx_expect(input logic [7:0] d, input logic [1:0] fl);
    repeat (3) @(negedge core_clk);
    rd(8'h99);
    chk({3'h0, rv}, {3'h0, d});
    rd(8'h98);
    chk({9'h000, rv[2], rv[0]}, {9'h000, fl});
    chk({10'h000, port_irq}, {10'h000, fl[0]});
  endtask : rx_expect
  task automatic t_regs();
    chk({10'h000, tx_room}, 11'h001);
    rd(8'h98);
    chk({3'h0, rv}, 11'h040);
    bw(8'h06, 1'b0);
    wr(8'h98, 8'h00);
    rd(8'h98);
    chk({3'h0, rv}, 11'h040);
    rd(8'h9A);
    chk({3'h0, rv}, 11'h000);
  endtask : t_regs
  task automatic t_tx8();
    wr(8'h99, 8'hA5);
    wr(8'h99, 8'h3C);
    tx_expect({2'b01, 8'hA5, 1'b0});
    tx_expect({2'b01, 8'h3C, 1'b0});
    repeat (20) @(negedge core_clk);
    rd(8'h98);
    chk({9'h000, rv[1], port_irq}, 11'h003);
    bw(8'h01, 1'b0);
    repeat (2) @(negedge core_clk);
    chk({10'h000, port_irq}, 11'h000);
  endtask : t_tx8
  // timer frozen: queue fills, one byte too many is dropped
  task automatic t_fill();
    t1_tick = 1'b0;
    chk({10'h000, tx_room}, 11'h001);
    for (int i = 0; i < 34; i++) begin
      wr(8'h99, 8'(i));
    end
    @(negedge core_clk);
    chk({10'h000, tx_room}, 11'h000);
    t1_tick = 1'b1;
    for (int i = 0; i < 33; i++) begin
      tx_expect({2'b01, 8'(i), 1'b0});
    end
    repeat (120) @(negedge core_clk);
    chk(11'(remote_u.got.size()), 11'h000);
    bw(8'h01, 1'b0);
  endtask : t_fill
  task automatic t_tx9();
    nine = 1'b1;
    bw(8'h07, 1'b1);
    for (int v = 0; v < 2; v++) begin
      bw(8'h03, v[0]);
      wr(8'h99, 8'hC3);
      tx_expect({1'b1, v[0], 8'hC3, 1'b0});
    end
    bw(8'h01, 1'b0);
  endtask : t_tx9
  task automatic t_rx8();
    nine = 1'b0;
    bw(8'h07, 1'b0);
    bw(8'h04, 1'b1);
    remote_u.send(8'h5A, 1'b0, 1'b1);
    rx_expect(8'h5A, 2'b11);
    remote_u.send(8'h77, 1'b0, 1'b1);
    rx_expect(8'h5A, 2'b11);
    bw(8'h00, 1'b0);
    bw(8'h05, 1'b1);
    remote_u.send(8'h33, 1'b0, 1'b0);
    rx_expect(8'h5A, 2'b10);
    remote_u.send(8'h34, 1'b0, 1'b1);
    rx_expect(8'h34, 2'b11);
    bw(8'h00, 1'b0);
    bw(8'h05, 1'b0);
    bw(8'h04, 1'b0);
    remote_u.send(8'h11, 1'b0, 1'b1);
    rx_expect(8'h34, 2'b10);
  endtask : t_rx8
  task automatic t_rx9();
    nine = 1'b1;
    bw(8'h07, 1'b1);
    bw(8'h04, 1'b1);
    bw(8'h05, 1'b1);
    remote_u.send(8'h21, 1'b0, 1'b1);
    rx_expect(8'h34, 2'b10);
    remote_u.send(8'h42, 1'b1, 1'b0);
    rx_expect(8'h42, 2'b11);
    bw(8'h00, 1'b0);
    bw(8'h05, 1'b0);
    remote_u.send(8'h43, 1'b0, 1'b1);
    rx_expect(8'h43, 2'b01);
  endtask : t_rx9
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    complete_run();
  end
  initial begin
    fails = 0;
    check_count = 0;
    sys_rst = 1'b1;
    t1_tick = 1'b1;
    t1_reload = 8'hFC;
    irq_enable = 1'b1;
    nine = 1'b0;
    sfr_req = '0;
    sfr_bit = '0;
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    t_regs();
    t_tx8();
    t_fill();
    t_tx9();
    t_rx8();
    t_rx9();
    complete_run();
  end
endmodule : ufm_uart_tb_top
